// ---- shared/gpio_port_map.svh ----
// Register offsets, field masks and reset values of the port control block
`ifndef GPIO_PORT_MAP_SVH
`define GPIO_PORT_MAP_SVH

`define PORTG_PIN_DATA_OFS        12'h000
`define PORTG_OUTPUT_ENABLE_OFS   12'h004
`define PORTG_FUNC_SEL_ONE_OFS    12'h008
`define PORTG_FUNC_SEL_TWO_OFS    12'h00C
`define PORTG_FUNC_SEL_THREE_OFS  12'h010
`define PORTG_OUTPUT_TYPE_OFS     12'h028
`define PORTG_PULLUP_ENABLE_OFS   12'h02C
`define PORTG_INPUT_ENABLE_OFS    12'h038

`define PORTF_TRACE_FUNC_SEL_OFS  12'h108
`define PORTF_OUTPUT_TYPE_OFS     12'h128
`define PORTF_PULLUP_ENABLE_OFS   12'h12C
`define PORTF_INPUT_ENABLE_OFS    12'h138

`define IRQ_STATUS_OFS            12'h200
`define IRQ_MASK_OFS              12'h204

`define PORTG_WIDTH               8
`define PORTF_WIDTH               5
`define IRQ_WIDTH                 2

`define PORTG_FULL_MASK           8'hFF
`define PORTG_FUNC_TWO_MASK       8'hF3
`define PORTG_FUNC_THREE_MASK     8'hCC
`define PORTF_FULL_MASK           5'h1F

`define PORTG_RESET               8'h00
`define PORTF_RESET               5'h00
`define IRQ_RESET                 2'h0

`define PORTG_INT6_PIN            3
`define PORTG_INT7_PIN            7

`endif

// ---- shared/gpio_port_pkg.sv ----
// Types shared by the port control block
`default_nettype none
package gpio_port_pkg;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WRITE,
    BUS_READ_WAIT
  } bus_phase_type;

  typedef logic [7:0] portg_bits_type;
  typedef logic [4:0] portf_bits_type;

endpackage : gpio_port_pkg
`default_nettype wire

// ---- rtl/gpio_port_pin_function_control.sv ----
// Pin function, drive and interrupt gating for two ports behind AHB-Lite
`timescale 1ns/10ps
`default_nettype none
`include "gpio_port_map.svh"

module gpio_port_pin_function_control
  import gpio_port_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [7:0]  portg_pin_in,
  output logic [7:0]       portg_pin_out,
  output logic [7:0]       portg_pin_oe,
  output logic [7:0]       portg_pullup,
  output logic [7:0]       portg_open_drain,
  input  wire logic [7:0]  periph_one_out,
  input  wire logic [7:0]  periph_one_oe,
  input  wire logic [7:0]  periph_two_out,
  input  wire logic [7:0]  periph_two_oe,
  input  wire logic [7:0]  periph_three_out,
  input  wire logic [7:0]  periph_three_oe,
  output logic [7:0]       periph_pin_in,
  output logic [1:0]       ext_interrupt,
  input  wire logic        stop_mode,
  input  wire logic        standby_pin_drive_enable,
  input  wire logic [4:0]  portf_pin_in,
  output logic [4:0]       portf_pin_out,
  output logic [4:0]       portf_pin_oe,
  output logic [4:0]       portf_pullup,
  output logic [4:0]       portf_open_drain,
  output logic [4:0]       portf_input_gated,
  input  wire logic        trace_clock_out,
  input  wire logic [3:0]  trace_data,
  input  wire logic        serial_wire_viewer_out,
  input  wire logic        serial_wire_viewer_en,
  output logic             irq
);

  portg_bits_type portg_pin_data_reg;
  portg_bits_type portg_output_enable_reg;
  portg_bits_type portg_function_select_one_reg;
  portg_bits_type portg_function_select_two_reg;
  portg_bits_type portg_function_select_three_reg;
  portg_bits_type portg_output_type_reg;
  portg_bits_type portg_pullup_enable_reg;
  portg_bits_type portg_input_enable_reg;
  portf_bits_type portf_trace_function_select_reg;
  portf_bits_type portf_output_type_reg;
  portf_bits_type portf_pullup_enable_reg;
  portf_bits_type portf_input_enable_reg;
  logic [1:0]     irq_status_reg;
  logic [1:0]     irq_mask_reg;

  bus_phase_type  phase_reg;
  logic [11:0]    addr_reg;
  logic           take_req;
  logic [7:0]     g_meta_reg;
  logic [7:0]     g_sync_reg;
  logic [4:0]     f_meta_reg;
  logic [4:0]     f_sync_reg;
  logic [1:0]     ext_int_prev_reg;
  logic [1:0]     ext_int_next;
  logic [1:0]     irq_status_next;
  logic [7:0]     g_out_next;
  logic [7:0]     g_oe_next;
  logic           drive_hold;
  logic [1:0]     irq_mask_next;

  assign take_req = hsel & hready & htrans[1];

  // Read decode, shared by the read data path
  function automatic logic [31:0] read_mux(input logic [11:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a == `PORTG_PIN_DATA_OFS) begin
      v[7:0] = g_sync_reg & portg_input_enable_reg;
    end else if (a == `PORTG_OUTPUT_ENABLE_OFS) begin
      v[7:0] = portg_output_enable_reg;
    end else if (a == `PORTG_FUNC_SEL_ONE_OFS) begin
      v[7:0] = portg_function_select_one_reg;
    end else if (a == `PORTG_FUNC_SEL_TWO_OFS) begin
      v[7:0] = portg_function_select_two_reg;
    end else if (a == `PORTG_FUNC_SEL_THREE_OFS) begin
      v[7:0] = portg_function_select_three_reg;
    end else if (a == `PORTG_OUTPUT_TYPE_OFS) begin
      v[7:0] = portg_output_type_reg;
    end else if (a == `PORTG_PULLUP_ENABLE_OFS) begin
      v[7:0] = portg_pullup_enable_reg;
    end else if (a == `PORTG_INPUT_ENABLE_OFS) begin
      v[7:0] = portg_input_enable_reg;
    end else if (a == `PORTF_TRACE_FUNC_SEL_OFS) begin
      v[4:0] = portf_trace_function_select_reg;
    end else if (a == `PORTF_OUTPUT_TYPE_OFS) begin
      v[4:0] = portf_output_type_reg;
    end else if (a == `PORTF_PULLUP_ENABLE_OFS) begin
      v[4:0] = portf_pullup_enable_reg;
    end else if (a == `PORTF_INPUT_ENABLE_OFS) begin
      v[4:0] = portf_input_enable_reg;
    end else if (a == `IRQ_STATUS_OFS) begin
      v[1:0] = irq_status_reg;
    end else if (a == `IRQ_MASK_OFS) begin
      v[1:0] = irq_mask_reg;
    end
    return v;
  endfunction : read_mux

  // Bus phase tracking; reads take one wait state so that a write
  // just before them has landed when the data is sampled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_reg <= BUS_IDLE;
      addr_reg  <= 12'h000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else begin
      hresp <= 1'b0;
      case (phase_reg)
        BUS_READ_WAIT: begin
          hrdata    <= read_mux(addr_reg);
          hreadyout <= 1'b1;
          phase_reg <= BUS_IDLE;
        end
        default: begin
          if (take_req) begin
            addr_reg  <= haddr[11:0];
            phase_reg <= hwrite ? BUS_WRITE : BUS_READ_WAIT;
            hreadyout <= hwrite;
          end else begin
            phase_reg <= BUS_IDLE;
          end
        end
      endcase
    end
  end

  // Register writes in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      portg_pin_data_reg              <= `PORTG_RESET;
      portg_output_enable_reg         <= `PORTG_RESET;
      portg_function_select_one_reg   <= `PORTG_RESET;
      portg_function_select_two_reg   <= `PORTG_RESET;
      portg_function_select_three_reg <= `PORTG_RESET;
      portg_output_type_reg           <= `PORTG_RESET;
      portg_pullup_enable_reg         <= `PORTG_RESET;
      portg_input_enable_reg          <= `PORTG_RESET;
      portf_trace_function_select_reg <= `PORTF_RESET;
      portf_output_type_reg           <= `PORTF_RESET;
      portf_pullup_enable_reg         <= `PORTF_RESET;
      portf_input_enable_reg          <= `PORTF_RESET;
      irq_mask_reg                    <= `IRQ_RESET;
    end else if (phase_reg == BUS_WRITE) begin
      if (addr_reg == `PORTG_PIN_DATA_OFS) begin
        portg_pin_data_reg <= hwdata[7:0];
      end else if (addr_reg == `PORTG_OUTPUT_ENABLE_OFS) begin
        portg_output_enable_reg <= hwdata[7:0];
      end else if (addr_reg == `PORTG_FUNC_SEL_ONE_OFS) begin
        portg_function_select_one_reg <= hwdata[7:0];
      end else if (addr_reg == `PORTG_FUNC_SEL_TWO_OFS) begin
        portg_function_select_two_reg <= hwdata[7:0] & `PORTG_FUNC_TWO_MASK;
      end else if (addr_reg == `PORTG_FUNC_SEL_THREE_OFS) begin
        portg_function_select_three_reg <=
          hwdata[7:0] & `PORTG_FUNC_THREE_MASK;
      end else if (addr_reg == `PORTG_OUTPUT_TYPE_OFS) begin
        portg_output_type_reg <= hwdata[7:0];
      end else if (addr_reg == `PORTG_PULLUP_ENABLE_OFS) begin
        portg_pullup_enable_reg <= hwdata[7:0];
      end else if (addr_reg == `PORTG_INPUT_ENABLE_OFS) begin
        portg_input_enable_reg <= hwdata[7:0];
      end else if (addr_reg == `PORTF_TRACE_FUNC_SEL_OFS) begin
        portf_trace_function_select_reg <= hwdata[4:0];
      end else if (addr_reg == `PORTF_OUTPUT_TYPE_OFS) begin
        portf_output_type_reg <= hwdata[4:0];
      end else if (addr_reg == `PORTF_PULLUP_ENABLE_OFS) begin
        portf_pullup_enable_reg <= hwdata[4:0];
      end else if (addr_reg == `PORTF_INPUT_ENABLE_OFS) begin
        portf_input_enable_reg <= hwdata[4:0];
      end else if (addr_reg == `IRQ_MASK_OFS) begin
        irq_mask_reg <= hwdata[1:0];
      end
    end
  end

  // Pin synchronisers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      g_meta_reg <= 8'h00;
      g_sync_reg <= 8'h00;
      f_meta_reg <= 5'h00;
      f_sync_reg <= 5'h00;
    end else begin
      g_meta_reg <= portg_pin_in;
      g_sync_reg <= g_meta_reg;
      f_meta_reg <= portf_pin_in;
      f_sync_reg <= f_meta_reg;
    end
  end

  // Pins stop driving in stop mode unless standby drive is kept
  assign drive_hold = stop_mode & ~standby_pin_drive_enable;

  genvar gi;
  generate
    for (gi = 0; gi < `PORTG_WIDTH; gi = gi + 1) begin : g_pin
      always_comb begin
        if (portg_function_select_one_reg[gi]) begin
          g_out_next[gi] = periph_one_out[gi];
          g_oe_next[gi]  = periph_one_oe[gi];
        end else if (portg_function_select_two_reg[gi]) begin
          g_out_next[gi] = periph_two_out[gi];
          g_oe_next[gi]  = periph_two_oe[gi];
        end else if (portg_function_select_three_reg[gi]) begin
          g_out_next[gi] = periph_three_out[gi];
          g_oe_next[gi]  = periph_three_oe[gi];
        end else begin
          g_out_next[gi] = portg_pin_data_reg[gi];
          g_oe_next[gi]  = portg_output_enable_reg[gi];
        end
        if (portg_output_type_reg[gi]) begin
          g_oe_next[gi]  = g_oe_next[gi] & ~g_out_next[gi];
          g_out_next[gi] = 1'b0;
        end
        if (drive_hold) begin
          g_oe_next[gi] = 1'b0;
        end
      end
    end
  endgenerate

  // External interrupt gating for the two interrupt pins
  always_comb begin
    if (stop_mode) begin
      ext_int_next[0] = g_sync_reg[`PORTG_INT6_PIN]
        & portg_input_enable_reg[`PORTG_INT6_PIN]
        & portg_function_select_one_reg[`PORTG_INT6_PIN];
      ext_int_next[1] = g_sync_reg[`PORTG_INT7_PIN]
        & portg_input_enable_reg[`PORTG_INT7_PIN]
        & portg_function_select_one_reg[`PORTG_INT7_PIN];
    end else begin
      ext_int_next[0] = g_sync_reg[`PORTG_INT6_PIN]
        & portg_input_enable_reg[`PORTG_INT6_PIN];
      ext_int_next[1] = g_sync_reg[`PORTG_INT7_PIN]
        & portg_input_enable_reg[`PORTG_INT7_PIN];
    end
  end

  // Mask as it stands after this edge, so irq never lags a mask write
  assign irq_mask_next = (phase_reg == BUS_WRITE && addr_reg == `IRQ_MASK_OFS)
    ? hwdata[1:0] : irq_mask_reg;

  // Sticky rising-edge status, write one to clear, set wins
  always_comb begin
    irq_status_next = irq_status_reg;
    if (phase_reg == BUS_WRITE && addr_reg == `IRQ_STATUS_OFS) begin
      irq_status_next = irq_status_next & ~hwdata[1:0];
    end
    irq_status_next = irq_status_next | (ext_int_next & ~ext_int_prev_reg);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_reg   <= `IRQ_RESET;
      ext_int_prev_reg <= `IRQ_RESET;
      ext_interrupt    <= `IRQ_RESET;
      irq              <= 1'b0;
    end else begin
      irq_status_reg   <= irq_status_next;
      ext_int_prev_reg <= ext_int_next;
      ext_interrupt    <= ext_int_next;
      irq              <= |(irq_status_next & irq_mask_next);
    end
  end

  // Registered pin outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      portg_pin_out     <= 8'h00;
      portg_pin_oe      <= 8'h00;
      portg_pullup      <= 8'h00;
      portg_open_drain  <= 8'h00;
      periph_pin_in     <= 8'h00;
      portf_pin_out     <= 5'h00;
      portf_pin_oe      <= 5'h00;
      portf_pullup      <= 5'h00;
      portf_open_drain  <= 5'h00;
      portf_input_gated <= 5'h00;
    end else begin
      portg_pin_out    <= g_out_next;
      portg_pin_oe     <= g_oe_next;
      portg_pullup     <= portg_pullup_enable_reg;
      portg_open_drain <= portg_output_type_reg;
      periph_pin_in    <= g_sync_reg & portg_input_enable_reg;
      portf_pin_out <= portf_trace_function_select_reg &
        {trace_data[3:2], trace_data[1] , trace_data[0] |
         (serial_wire_viewer_en & serial_wire_viewer_out), trace_clock_out};
      portf_pin_oe  <= drive_hold ? 5'h00 : portf_trace_function_select_reg;
      portf_pullup      <= portf_pullup_enable_reg;
      portf_open_drain  <= portf_output_type_reg;
      portf_input_gated <= f_sync_reg & portf_input_enable_reg;
    end
  end

  // Checks
  sequence s_read_taken;
    hsel && hready && htrans[1] && !hwrite && phase_reg != BUS_READ_WAIT;
  endsequence
  sequence s_read_done;
    !hreadyout ##1 hreadyout;
  endsequence
  a_read_wait_state: assert property (@(posedge hclk) disable iff (!hresetn)
    s_read_taken |=> s_read_done) else $error("read wait state wrong");
  a_data_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (phase_reg == BUS_READ_WAIT && addr_reg == `PORTG_PIN_DATA_OFS)
    |=> hrdata[31:8] == 24'h000000) else $error("data upper bits set");
  a_data_read_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    (phase_reg == BUS_READ_WAIT && addr_reg == `PORTG_PIN_DATA_OFS)
    |=> hrdata[7:0] == $past(g_sync_reg & portg_input_enable_reg))
    else $error("data read not gated by input enable");
  a_plain_pin_oe: assert property (@(posedge hclk) disable iff (!hresetn)
    (portg_function_select_one_reg[0] == 1'b0 &&
     portg_function_select_two_reg[0] == 1'b0 &&
     portg_function_select_three_reg[0] == 1'b0 &&
     !portg_output_type_reg[0] && !drive_hold)
    |=> portg_pin_oe[0] == $past(portg_output_enable_reg[0]))
    else $error("plain pin enable mismatch");
  a_stop_int_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    (stop_mode && !portg_function_select_one_reg[`PORTG_INT7_PIN])
    |=> !ext_interrupt[1]) else $error("stop interrupt not gated");
  a_run_int_pass: assert property (@(posedge hclk) disable iff (!hresetn)
    (!stop_mode && portg_input_enable_reg[`PORTG_INT6_PIN] &&
     g_sync_reg[`PORTG_INT6_PIN]) |=> ext_interrupt[0])
    else $error("interrupt blocked outside stop");
  a_reset_idle: assert property (@(posedge hclk)
    !hresetn |=> (portg_pin_oe == 8'h00 && portg_pullup == 8'h00))
    else $error("pins active after reset");
  a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
    irq == |(irq_status_reg & irq_mask_reg))
    else $error("irq level mismatch");
  a_open_drain_low: assert property (@(posedge hclk) disable iff (!hresetn)
    portg_open_drain[2] && portg_pin_oe[2] |-> !portg_pin_out[2])
    else $error("open-drain pin driven high");
endmodule : gpio_port_pin_function_control
`default_nettype wire

// ---- verification/pin_world_model.sv ----
// Board around one port: external drivers, pull-ups and released lines
`timescale 1ns/10ps
`default_nettype none

module pin_world_model #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] drive_out,
  input  wire logic [W-1:0] drive_oe,
  input  wire logic [W-1:0] pull_up,
  input  wire logic [W-1:0] ext_val,
  input  wire logic [W-1:0] ext_en,
  output logic      [W-1:0] level
);
  logic [W-1:0] churn_reg = '0;

  // A released line without pull-up keeps changing
  always_ff @(posedge clk) begin
    churn_reg <= {churn_reg[W-2:0], ~churn_reg[W-1]};
  end

  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (drive_oe[i]) begin
        level[i] = drive_out[i];
      end else if (ext_en[i]) begin
        level[i] = ext_val[i];
      end else if (pull_up[i]) begin
        level[i] = 1'b1;
      end else begin
        level[i] = churn_reg[i];
      end
    end
  end
endmodule : pin_world_model
`default_nettype wire

// ---- verification/gpio_port_pin_function_control_test.sv ----
// Self-checking bench for the port control block
`timescale 1ns/10ps
`default_nettype none
`include "gpio_port_map.svh"

module gpio_port_pin_function_control_test;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, irq, stop_mode, hresp;
  logic        standby_pin_drive_enable, trace_clock_out;
  logic        serial_wire_viewer_out, serial_wire_viewer_en;
  logic [31:0] haddr, hwdata, hrdata, rd, r, r2;
  logic [1:0]  htrans, ext_interrupt;
  logic [2:0]  hsize;
  logic [3:0]  trace_data;
  logic [7:0]  portg_pin_in, portg_pin_out, portg_pin_oe, portg_pullup;
  logic [7:0]  portg_open_drain, periph_pin_in, g_ext, g_ext_en;
  logic [7:0]  periph_one_out, periph_one_oe, periph_two_out, periph_two_oe;
  logic [7:0]  periph_three_out, periph_three_oe, oe_x, lvl, m, po, pe;
  logic [4:0]  portf_pin_in, portf_pin_out, portf_pin_oe, portf_pullup;
  logic [4:0]  portf_open_drain, portf_input_gated, f_ext, f_ext_en, fx;
  int          fail_count = 0;
  int          total_checks = 0;
  logic [11:0] addr_tab [14] = '{`PORTG_PIN_DATA_OFS,
    `PORTG_OUTPUT_ENABLE_OFS, `PORTG_FUNC_SEL_ONE_OFS, `PORTG_FUNC_SEL_TWO_OFS,
    `PORTG_FUNC_SEL_THREE_OFS, `PORTG_OUTPUT_TYPE_OFS,
    `PORTG_PULLUP_ENABLE_OFS, `PORTG_INPUT_ENABLE_OFS,
    `PORTF_TRACE_FUNC_SEL_OFS, `PORTF_OUTPUT_TYPE_OFS,
    `PORTF_PULLUP_ENABLE_OFS, `PORTF_INPUT_ENABLE_OFS, `IRQ_MASK_OFS,
    `IRQ_STATUS_OFS};
  logic [31:0] mask_tab [14] = '{32'hFF, 32'hFF, 32'hFF, 32'hF3, 32'hCC,
    32'hFF, 32'hFF, 32'hFF, 32'h1F, 32'h1F, 32'h1F, 32'h1F, 32'h3, 32'h3};

  gpio_port_pin_function_control dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .portg_pin_in,
    .portg_pin_out, .portg_pin_oe, .portg_pullup, .portg_open_drain,
    .periph_one_out, .periph_one_oe, .periph_two_out, .periph_two_oe,
    .periph_three_out, .periph_three_oe, .periph_pin_in, .ext_interrupt,
    .stop_mode, .standby_pin_drive_enable, .portf_pin_in, .portf_pin_out,
    .portf_pin_oe, .portf_pullup, .portf_open_drain, .portf_input_gated,
    .trace_clock_out, .trace_data, .serial_wire_viewer_out,
    .serial_wire_viewer_en, .irq);

  pin_world_model #(.W(8)) g_world (.clk(hclk), .drive_out(portg_pin_out),
    .drive_oe(portg_pin_oe), .pull_up(portg_pullup), .ext_val(g_ext),
    .ext_en(g_ext_en), .level(portg_pin_in));
  pin_world_model #(.W(5)) f_world (.clk(hclk), .drive_out(portf_pin_out),
    .drive_oe(portf_pin_oe), .pull_up(portf_pullup), .ext_val(f_ext),
    .ext_en(f_ext_en), .level(portf_pin_in));

  task automatic summarize;
    if (fail_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      summarize();
    end
  endtask : wait_ready

  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask : bus

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(64'(rd), 64'(exp));
  endtask : rdchk

  task automatic settle;
    repeat (5) @(posedge hclk);
  endtask : settle

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  initial begin
    #100000;
    fail_count++;
    summarize();
  end

  initial begin
    {hresetn, hsel, hwrite, stop_mode, haddr, hwdata, htrans} = '0;
    standby_pin_drive_enable = 1'b1;
    hsize = 3'h2;
    {periph_one_out, periph_one_oe, periph_two_out, periph_two_oe} = '0;
    {periph_three_out, periph_three_oe, g_ext, g_ext_en} = '0;
    {f_ext, f_ext_en, trace_clock_out, trace_data} = '0;
    {serial_wire_viewer_out, serial_wire_viewer_en} = '0;
    void'($urandom(32'h3EFF591A));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 14; i++) rdchk(addr_tab[i], 32'h0);
    check(64'({portg_pin_oe, portg_pullup, portf_pin_oe, portf_pullup,
               portf_open_drain, irq, hresp}), 64'h0);
    // one register, output enable to IRQ mask, holds ones at a time
    for (int i = 1; i < 13; i++) begin
      for (int n = 0; n < 3; n++) begin
        r = n ? $urandom : 32'hFFFFFFFF;
        bus(1'b1, addr_tab[i], r);
        rdchk(addr_tab[i], r & mask_tab[i]);
        bus(1'b1, addr_tab[i], 32'h0);
      end
    end
    bus(1'b1, 12'h014, 32'hFFFFFFFF);
    rdchk(12'h014, 32'h0);
    repeat (6) begin
      r = $urandom;
      r2 = $urandom;
      oe_x = r[7:0] & ~(r[23:16] & r[15:8]);
      g_ext_en <= ~oe_x;
      g_ext <= r2[7:0];
      bus(1'b1, `PORTG_OUTPUT_ENABLE_OFS, {24'h0, r[7:0]});
      bus(1'b1, `PORTG_PIN_DATA_OFS, {24'h0, r[15:8]});
      bus(1'b1, `PORTG_OUTPUT_TYPE_OFS, {24'h0, r[23:16]});
      bus(1'b1, `PORTG_PULLUP_ENABLE_OFS, {24'h0, r2[15:8]});
      bus(1'b1, `PORTG_INPUT_ENABLE_OFS, {24'h0, r[31:24]});
      settle();
      lvl = ((oe_x & r[15:8]) | (~oe_x & r2[7:0])) & r[31:24];
      check(64'(portg_pin_oe), 64'(oe_x));
      check(64'(portg_pin_out & oe_x), 64'(r[15:8] & oe_x));
      check(64'({portg_pullup, portg_open_drain}),
            64'({r2[15:8], r[23:16]}));
      check(64'(periph_pin_in), 64'(lvl));
      rdchk(`PORTG_PIN_DATA_OFS, {24'h0, lvl});
    end
    bus(1'b1, `PORTG_OUTPUT_ENABLE_OFS, 32'h0);
    bus(1'b1, `PORTG_OUTPUT_TYPE_OFS, 32'h0);
    bus(1'b1, `PORTG_INPUT_ENABLE_OFS, 32'h0);
    for (int k = 0; k < 3; k++) begin
      {periph_one_out, periph_one_oe, periph_two_out} <= 24'($urandom);
      {periph_two_oe, periph_three_out, periph_three_oe} <= 24'($urandom);
      bus(1'b1, addr_tab[k + 2], mask_tab[k + 2]);
      settle();
      m = mask_tab[k + 2][7:0];
      po = (k == 0) ? periph_one_out : (k == 1) ? periph_two_out
                                                 : periph_three_out;
      pe = (k == 0) ? periph_one_oe : (k == 1) ? periph_two_oe
                                                : periph_three_oe;
      check(64'({portg_pin_out & m & pe, portg_pin_oe & m}),
            64'({po & m & pe, pe & m}));
      bus(1'b1, addr_tab[k + 2], 32'h0);
    end
    bus(1'b1, `PORTF_TRACE_FUNC_SEL_OFS, 32'h1F);
    repeat (4) begin
      r = $urandom;
      {trace_clock_out, trace_data} <= r[6:2];
      {serial_wire_viewer_out, serial_wire_viewer_en} <= r[1:0];
      bus(1'b1, `PORTF_INPUT_ENABLE_OFS, {27'h0, r[11:7]});
      bus(1'b1, `PORTF_PULLUP_ENABLE_OFS, {27'h0, r[16:12]});
      settle();
      fx = {r[5:3], r[2] | (r[1] & r[0]), r[6]};
      check(64'({portf_pin_out, portf_pin_oe}), 64'({fx, 5'h1F}));
      check(64'(portf_input_gated), 64'(fx & r[11:7]));
      check(64'(portf_pullup), 64'(r[16:12]));
    end
    bus(1'b1, `PORTF_OUTPUT_TYPE_OFS, 32'h15);
    settle();
    check(64'(portf_open_drain), 64'h15);
    g_ext_en <= 8'hFF;
    g_ext <= 8'h00;
    bus(1'b1, `PORTG_INPUT_ENABLE_OFS, 32'h88);
    bus(1'b1, `IRQ_MASK_OFS, 32'h1);
    settle();
    bus(1'b1, `IRQ_STATUS_OFS, 32'h3);
    rdchk(`IRQ_STATUS_OFS, 32'h0);
    check(64'(irq), 64'h0);
    g_ext <= 8'h88;
    settle();
    check(64'({ext_interrupt, irq}), 64'h7);
    rdchk(`IRQ_STATUS_OFS, 32'h3);
    bus(1'b1, `IRQ_STATUS_OFS, 32'h1);
    rdchk(`IRQ_STATUS_OFS, 32'h2);
    check(64'(irq), 64'h0);
    stop_mode <= 1'b1;
    standby_pin_drive_enable <= 1'b0;
    settle();
    check(64'(ext_interrupt), 64'h0);
    bus(1'b1, `PORTG_FUNC_SEL_ONE_OFS, 32'h80);
    settle();
    check(64'(ext_interrupt), 64'h2);
    stop_mode <= 1'b0;
    standby_pin_drive_enable <= 1'b1;
    bus(1'b1, `PORTG_INPUT_ENABLE_OFS, 32'h0);
    bus(1'b1, `IRQ_MASK_OFS, 32'h2);
    settle();
    check(64'({ext_interrupt, irq, hresp}), 64'h2);
    summarize();
  end
endmodule : gpio_port_pin_function_control_test
`default_nettype wire
